// file: logic/wwdt_regs.svh
`ifndef WWDT_REGS_SVH
`define WWDT_REGS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define WWDT_ADDR_SERVICE_CMD  32'h400E1850
`define WWDT_ADDR_CONFIG       32'h400E1854
`define WWDT_ADDR_FAULT_STATUS 32'h400E1858
`define WWDT_ADDR_IRQ_STATUS   32'h400E185C
`define WWDT_ADDR_IRQ_MASK     32'h400E1860

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define WWDT_KEY_MSB           31
`define WWDT_KEY_LSB           24
`define WWDT_SERVICE_KEY       8'hA5
`define WWDT_RESTART_BIT       0
`define WWDT_COUNTER_W         12
`define WWDT_FLAG_W            2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define WWDT_CONFIG_RESET      32'h3FFF2FFF
`define WWDT_IRQ_MASK_RESET    2'h3
`define WWDT_PRESCALE_DIV      128

`endif

// file: logic/wwdt_pkg.sv
package wwdt_pkg;

`include "wwdt_regs.svh"

// ----------------------------------------
// configuration word layout
// ----------------------------------------
typedef struct packed {
    logic [1:0]                 reserved;
    logic                       idle_halt;
    logic                       debug_halt;
    logic [`WWDT_COUNTER_W-1:0] window_delta;
    logic                       timer_disable;
    logic                       processor_reset_only;
    logic                       fault_reset_enable;
    logic                       fault_irq_enable;
    logic [`WWDT_COUNTER_W-1:0] counter_reload_value;
} wwdt_cfg_t;

// ----------------------------------------
// fault flags, also the irq status layout
// ----------------------------------------
typedef struct packed {
    logic window_error_flag;
    logic underflow_flag;
} wwdt_flags_t;

// ----------------------------------------
// register select
// ----------------------------------------
typedef enum logic [2:0] {
    WWDT_SEL_NONE  = 3'b000,
    WWDT_SEL_CMD   = 3'b001,
    WWDT_SEL_CFG   = 3'b010,
    WWDT_SEL_STAT  = 3'b011,
    WWDT_SEL_ISTAT = 3'b100,
    WWDT_SEL_IMASK = 3'b101
} wwdt_sel_t;

endpackage

// file: logic/wwdt_prescaler.sv
`timescale 1ns/1ps
`include "wwdt_regs.svh"

module wwdt_prescaler #(
    parameter int unsigned DIV = `WWDT_PRESCALE_DIV
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   clear,
    input  wire logic                   run,
    output logic                        tick,
    output logic [$clog2(DIV)-1:0]      phase
);

    localparam int unsigned      W    = $clog2(DIV);
    localparam logic [W-1:0]     LAST = W'(DIV - 1);

    // one tick every DIV running cycles
    assign tick = ce & run & ~clear & (phase == LAST);

    // ----------------------------------------
    // phase counter
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= '0;
        end else if (ce) begin
            if (clear) begin
                phase <= '0;
            end else if (run) begin
                phase <= tick ? '0 : phase + 1'b1;
            end
        end
    end

endmodule // wwdt_prescaler

// file: logic/wwdt_top.sv
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "wwdt_regs.svh"

module wwdt_top #(
    parameter int unsigned PRESCALE_DIV = `WWDT_PRESCALE_DIV
) (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic                CE,
    input  wire logic                WB_CYC_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_WE_I,
    input  wire logic [31:0]         WB_ADR_I,
    input  wire logic [3:0]          WB_SEL_I,
    input  wire logic [31:0]         WB_DAT_I,
    output logic      [31:0]         WB_DAT_O,
    output logic                     WB_ACK_O,
    input  wire logic                DEBUG_STATE,
    input  wire logic                IDLE_STATE,
    output logic                     IRQ,
    output logic                     FAULT_RESET_ALL,
    output logic                     FAULT_RESET_PROC,
    output wwdt_pkg::wwdt_flags_t    FAULT_STATUS
);

    import wwdt_pkg::*;

    localparam int unsigned          CW      = `WWDT_COUNTER_W;
    localparam int unsigned          PW      = $clog2(PRESCALE_DIV);
    localparam wwdt_cfg_t            CFG_RST = `WWDT_CONFIG_RESET;
    localparam logic [CW-1:0]        CNT_ZERO = '0;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic wwdt_sel_t decode(input logic [31:0] adr);
        case (adr)
            `WWDT_ADDR_SERVICE_CMD:  decode = WWDT_SEL_CMD;
            `WWDT_ADDR_CONFIG:       decode = WWDT_SEL_CFG;
            `WWDT_ADDR_FAULT_STATUS: decode = WWDT_SEL_STAT;
            `WWDT_ADDR_IRQ_STATUS:   decode = WWDT_SEL_ISTAT;
            `WWDT_ADDR_IRQ_MASK:     decode = WWDT_SEL_IMASK;
            default:                 decode = WWDT_SEL_NONE;
        endcase
    endfunction

    wwdt_sel_t                       sel;
    logic                            req;
    logic                            wr;
    logic                            rd;
    logic                            full_word;
    logic                            cmd_wr;
    logic                            key_ok;
    logic                            svc_restart;
    logic                            in_window;
    logic                            restart_ok;
    logic                            window_err;
    logic                            cfg_wr;
    logic                            cfg_locked;
    logic                            stat_rd;
    logic                            halted;
    logic                            reload;
    logic                            tick;
    logic                            underflow;
    logic                            fault_evt;
    logic [PW-1:0]                   phase;
    logic [CW-1:0]                   count;
    logic [CW-1:0]                   next_reload;
    wwdt_cfg_t                       cfg;
    wwdt_cfg_t                       new_cfg;
    wwdt_flags_t                     events;
    wwdt_flags_t                     irq_status;
    wwdt_flags_t                     irq_mask;
    wwdt_flags_t                     next_irq_status;

    // bus request taken on the edge that raises ack
    assign sel       = decode(WB_ADR_I);
    assign req       = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr        = req & WB_WE_I;
    assign rd        = req & ~WB_WE_I;
    assign full_word = &WB_SEL_I;

    // service command qualification
    assign cmd_wr      = wr & full_word & (sel == WWDT_SEL_CMD);
    assign key_ok      = WB_DAT_I[`WWDT_KEY_MSB:`WWDT_KEY_LSB] == `WWDT_SERVICE_KEY;
    assign svc_restart = cmd_wr & key_ok & WB_DAT_I[`WWDT_RESTART_BIT];
    assign in_window   = count <= cfg.window_delta;
    assign restart_ok  = svc_restart & in_window;
    assign window_err  = svc_restart & ~in_window;

    // write-once configuration strobe
    assign cfg_wr  = wr & full_word & (sel == WWDT_SEL_CFG) & ~cfg_locked;
    assign stat_rd = rd & (sel == WWDT_SEL_STAT);

    // new configuration word, reserved bits dropped
    always_comb begin
        new_cfg          = wwdt_cfg_t'(WB_DAT_I);
        new_cfg.reserved = '0;
    end

    // counting gates
    assign halted = cfg.timer_disable
                  | (cfg.debug_halt & DEBUG_STATE)
                  | (cfg.idle_halt & IDLE_STATE);
    assign reload      = restart_ok | cfg_wr;
    assign next_reload = cfg_wr ? new_cfg.counter_reload_value : cfg.counter_reload_value;
    assign underflow   = tick & (count == CNT_ZERO);
    assign events      = '{window_error_flag: window_err, underflow_flag: underflow};
    assign fault_evt   = underflow | window_err;

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    wwdt_prescaler #(
        .DIV   (PRESCALE_DIV)
    ) u_prescaler (
        .clk   (CLK),
        .rst   (RST),
        .ce    (CE),
        .clear (reload),
        .run   (~halted),
        .tick  (tick),
        .phase (phase)
    );

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg        <= CFG_RST;
            cfg_locked <= 1'b0;
        end else if (CE && cfg_wr) begin
            cfg        <= new_cfg;
            cfg_locked <= 1'b1;
        end
    end

    // ----------------------------------------
    // down counter
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            count <= CFG_RST.counter_reload_value;
        end else if (CE) begin
            if (reload) begin
                count <= next_reload;
            end else if (underflow) begin
                count <= cfg.counter_reload_value;
            end else if (tick) begin
                count <= count - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // fault flags, set wins over read clear
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            FAULT_STATUS <= '0;
        end else if (CE) begin
            FAULT_STATUS <= (stat_rd ? '0 : FAULT_STATUS) | events;
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    always_comb begin
        next_irq_status = irq_status;
        if (stat_rd) begin
            next_irq_status = '0;
        end else if (wr && sel == WWDT_SEL_ISTAT && WB_SEL_I[0]) begin
            next_irq_status = irq_status & ~wwdt_flags_t'(WB_DAT_I[`WWDT_FLAG_W-1:0]);
        end
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_status <= '0;
            irq_mask   <= `WWDT_IRQ_MASK_RESET;
        end else if (CE) begin
            irq_status <= next_irq_status;
            if (wr && sel == WWDT_SEL_IMASK && WB_SEL_I[0]) begin
                irq_mask <= wwdt_flags_t'(WB_DAT_I[`WWDT_FLAG_W-1:0]);
            end
        end
    end

    // interrupt output, gated by the config enable
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= cfg.fault_irq_enable & (|(next_irq_status & irq_mask));
        end
    end

    // ----------------------------------------
    // fault request to the reset controller
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            FAULT_RESET_ALL  <= 1'b0;
            FAULT_RESET_PROC <= 1'b0;
        end else if (CE) begin
            FAULT_RESET_ALL  <= (~stat_rd & FAULT_RESET_ALL)
                              | (fault_evt & cfg.fault_reset_enable & ~cfg.processor_reset_only);
            FAULT_RESET_PROC <= (~stat_rd & FAULT_RESET_PROC)
                              | (fault_evt & cfg.fault_reset_enable & cfg.processor_reset_only);
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
        end else if (CE) begin
            WB_ACK_O <= req;
        end
    end

    // read data captured with the request, unmapped reads give zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_DAT_O <= '0;
        end else if (CE && rd) begin
            case (sel)
                WWDT_SEL_CFG:   WB_DAT_O <= cfg;
                WWDT_SEL_STAT:  WB_DAT_O <= {30'h0, FAULT_STATUS};
                WWDT_SEL_ISTAT: WB_DAT_O <= {30'h0, irq_status};
                WWDT_SEL_IMASK: WB_DAT_O <= {30'h0, irq_mask};
                default:        WB_DAT_O <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST || !CE);

    property p_key_guard;
        cmd_wr && !key_ok && !underflow |=> $stable(FAULT_STATUS) && (count == $past(count) || $past(tick));
    endproperty
    a_key_guard: assert property (p_key_guard) else $error("bad key write changed state");

    property p_reload_value;
        reload |=> count == $past(next_reload) && phase == '0;
    endproperty
    a_reload_value: assert property (p_reload_value) else $error("reload value wrong");

    property p_irq_on_fault;
        underflow && cfg.fault_irq_enable && irq_mask.underflow_flag |=> IRQ;
    endproperty
    a_irq_on_fault: assert property (p_irq_on_fault) else $error("fault gave no irq");

    property p_irq_gated;
        !cfg.fault_irq_enable |=> !IRQ;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq while disabled");

    property p_reset_req;
        fault_evt && cfg.fault_reset_enable |=> FAULT_RESET_ALL || FAULT_RESET_PROC;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("fault gave no reset request");

    property p_no_reset;
        !cfg.fault_reset_enable && !FAULT_RESET_ALL && !FAULT_RESET_PROC |=> !FAULT_RESET_ALL && !FAULT_RESET_PROC;
    endproperty
    a_no_reset: assert property (p_no_reset) else $error("reset request while disabled");

    property p_proc_scope;
        fault_evt && cfg.fault_reset_enable && cfg.processor_reset_only |=> FAULT_RESET_PROC;
    endproperty
    a_proc_scope: assert property (p_proc_scope) else $error("processor scope not requested");

    property p_restart_ok;
        svc_restart && count <= cfg.window_delta |=> count == $past(cfg.counter_reload_value);
    endproperty
    a_restart_ok: assert property (p_restart_ok) else $error("restart did not reload");

    property p_window_err;
        svc_restart && count > cfg.window_delta && !tick |=> count == $past(count) && FAULT_STATUS.window_error_flag;
    endproperty
    a_window_err: assert property (p_window_err) else $error("early restart not flagged");

    property p_debug_halt;
        cfg.debug_halt && DEBUG_STATE && !reload |=> $stable(count);
    endproperty
    a_debug_halt: assert property (p_debug_halt) else $error("counted in debug halt");

    property p_idle_halt;
        cfg.idle_halt && IDLE_STATE && !reload |=> $stable(count) && $stable(phase);
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("counted in idle halt");

    property p_disabled;
        cfg.timer_disable && !reload |=> $stable(count) && !FAULT_STATUS.underflow_flag || $past(FAULT_STATUS.underflow_flag);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled timer moved");

    property p_underflow_flag;
        underflow |=> FAULT_STATUS.underflow_flag && count == $past(cfg.counter_reload_value);
    endproperty
    a_underflow_flag: assert property (p_underflow_flag) else $error("underflow not flagged");

    property p_window_flag;
        window_err |=> FAULT_STATUS.window_error_flag;
    endproperty
    a_window_flag: assert property (p_window_flag) else $error("window error not flagged");

    property p_tick_period;
        reload && !halted ##1 (!halted && !reload) [*8] |-> phase == PW'(3'h7);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("prescaler not restarted");

    property p_cfg_once;
        cfg_locked && wr && sel == WWDT_SEL_CFG |=> $stable(cfg);
    endproperty
    a_cfg_once: assert property (p_cfg_once) else $error("second config write accepted");

    property p_read_clear;
        stat_rd && !fault_evt |=> FAULT_STATUS == '0 && !IRQ && !FAULT_RESET_ALL && !FAULT_RESET_PROC;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

    c_underflow:  cover property (underflow);
    c_window_err: cover property (window_err);
    c_restart:    cover property (restart_ok);
    c_cfg_write:  cover property (cfg_wr);

endmodule // wwdt_top

// file: test/test_windowed_watchdog_timer.sv
`timescale 1ns/1ps
`include "wwdt_regs.svh"

module test_windowed_watchdog_timer;
    import wwdt_pkg::*;

    localparam int unsigned DIV    = 16;
    localparam logic [31:0] KEY_OK = 32'hA5000001;

    logic        clk;
    logic        rst;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [31:0] wb_adr;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack;
    logic        dbg;
    logic        idle;
    logic        irq;
    logic        rst_all;
    logic        rst_proc;
    wwdt_flags_t fault_status;
    integer      mismatches;
    integer      cmp_count;

    // ----------------------------------------
    // clock and device
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    wwdt_top #(.PRESCALE_DIV(DIV)) u_dut (
        .CLK(clk), .RST(rst), .CE(1'b1), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
        .WB_ADR_I(wb_adr), .WB_SEL_I(4'hF), .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack),
        .DEBUG_STATE(dbg), .IDLE_STATE(idle), .IRQ(irq), .FAULT_RESET_ALL(rst_all),
        .FAULT_RESET_PROC(rst_proc), .FAULT_STATUS(fault_status)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches = mismatches + 1;
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (wb_ack !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        if (n >= 20) begin
            mismatches = mismatches + 1;
            conclude();
        end
    endtask

    task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb(1'b1, adr, dat, q);
    endtask

    task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 32'h00000000, q);
        chk(q, exp);
    endtask

    // bounded wait for any fault flag
    task automatic wait_flags(input int limit, output int n);
        n = 0;
        while (fault_status === 2'h0 && n < limit) begin
            @(negedge clk);
            n = n + 1;
        end
        if (fault_status === 2'h0) begin
            mismatches = mismatches + 1;
            conclude();
        end
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst  <= 1'b1;
        dbg  <= 1'b0;
        idle <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        do_reset();
        @(negedge clk);
        chk({27'h0, irq, rst_all, rst_proc, fault_status}, 32'h0);
        rd_chk(`WWDT_ADDR_CONFIG, `WWDT_CONFIG_RESET);
        rd_chk(`WWDT_ADDR_FAULT_STATUS, 32'h00000000);
        rd_chk(`WWDT_ADDR_SERVICE_CMD, 32'h00000000);
        rd_chk(32'h400E1900, 32'h00000000);
        rd_chk(`WWDT_ADDR_IRQ_MASK, 32'h00000003);
        $display("test reset done");
    endtask

    task automatic t_window_error;
        do_reset();
        wr(`WWDT_ADDR_CONFIG, 32'h00013020);
        wr(`WWDT_ADDR_CONFIG, 32'h0FFF0FFF);
        rd_chk(`WWDT_ADDR_CONFIG, 32'h00013020);
        wr(`WWDT_ADDR_SERVICE_CMD, 32'h5A000001);
        repeat (3) @(negedge clk);
        chk({30'h0, fault_status}, 32'h0);
        wr(`WWDT_ADDR_SERVICE_CMD, KEY_OK);
        @(negedge clk);
        chk({30'h0, fault_status}, 32'h2);
        chk({29'h0, irq, rst_all, rst_proc}, 32'h6);
        rd_chk(`WWDT_ADDR_FAULT_STATUS, 32'h00000002);
        @(negedge clk);
        chk({29'h0, irq, rst_all, rst_proc}, 32'h0);
        rd_chk(`WWDT_ADDR_FAULT_STATUS, 32'h00000000);
        $display("test window error done");
    endtask

    task automatic t_underflow;
        int n;
        int i;
        do_reset();
        wr(`WWDT_ADDR_CONFIG, 32'h0FFF6002);
        for (i = 0; i < 2; i++) begin
            wait_flags(100, n);
            chk({31'h0, n >= 44 && n <= 52}, 32'h1);
            chk({28'h0, irq, rst_all, rst_proc, fault_status[0]}, 32'h3);
            rd_chk(`WWDT_ADDR_FAULT_STATUS, 32'h00000001);
        end
        $display("test underflow done");
    endtask

    task automatic t_irq_mask;
        int n;
        do_reset();
        wr(`WWDT_ADDR_IRQ_MASK, 32'h00000000);
        wr(`WWDT_ADDR_CONFIG, 32'h0FFF1008);
        wait_flags(300, n);
        chk({30'h0, irq, fault_status[0]}, 32'h1);
        wr(`WWDT_ADDR_IRQ_MASK, 32'h00000003);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(`WWDT_ADDR_IRQ_STATUS, 32'h00000001);
        wr(`WWDT_ADDR_IRQ_STATUS, 32'h00000001);
        @(negedge clk);
        chk({29'h0, irq, rst_all, rst_proc}, 32'h0);
        $display("test irq mask done");
    endtask

    // h = 1: debug halts, idle runs; h = 0: the other way round
    task automatic t_halt(input logic [31:0] cfg, input logic h);
        int n;
        do_reset();
        wr(`WWDT_ADDR_CONFIG, cfg);
        dbg  <= h;
        idle <= ~h;
        repeat (200) @(negedge clk);
        chk({30'h0, fault_status}, 32'h0);
        @(posedge clk);
        dbg  <= ~h;
        idle <= h;
        wait_flags(100, n);
        chk({30'h0, fault_status}, 32'h1);
        $display("test halt done");
    endtask

    task automatic t_disable;
        do_reset();
        wr(`WWDT_ADDR_CONFIG, 32'h00008005);
        repeat (200) @(negedge clk);
        chk({30'h0, fault_status}, 32'h0);
        wr(`WWDT_ADDR_SERVICE_CMD, KEY_OK);
        @(negedge clk);
        chk({30'h0, fault_status}, 32'h2);
        $display("test disable done");
    endtask

    // restarts every ~20 cycles only survive if the prescaler restarts too
    task automatic t_restart;
        do_reset();
        wr(`WWDT_ADDR_CONFIG, 32'h0FFF0001); // config fixed before restarts begin
        repeat (8) begin
            repeat (17) @(posedge clk);
            wr(`WWDT_ADDR_SERVICE_CMD, KEY_OK);
        end
        @(negedge clk);
        chk({30'h0, fault_status}, 32'h0);
        $display("test restart done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        mismatches = 0;
        cmp_count  = 0;
        rst        = 1'b1;
        wb_cyc     = 1'b0;
        wb_stb     = 1'b0;
        wb_we      = 1'b0;
        wb_adr     = 32'h00000000;
        wb_dat_i   = 32'h00000000;
        dbg        = 1'b0;
        idle       = 1'b0;
        t_reset();
        t_window_error();
        t_underflow();
        t_irq_mask();
        t_halt(32'h1FFF0001, 1'b1);
        t_halt(32'h2FFF0001, 1'b0);
        t_disable();
        t_restart();
        conclude();
    end

endmodule // test_windowed_watchdog_timer
